// file: gsc_pkg.sv
/*
  Package for the gauge status and capacity register bank.
  Holds register indices, status bit positions, health codes and carrier structs.
  Assumes an AHB-Lite slave with 32-bit data and one aligned word per register.
*/
package gsc_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  // Printed command codes are not all multiples of four, so each code is an
  // index and the byte address is four times the index.
  localparam logic [7:0] IDX_STATUS_LO = 8'h0A;
  localparam logic [7:0] IDX_STATUS_HI = 8'h0B;
  localparam logic [7:0] IDX_UNC_REM_LO = 8'h0C;
  localparam logic [7:0] IDX_UNC_REM_HI = 8'h0D;
  localparam logic [7:0] IDX_UNC_FULL_LO = 8'h0E;
  localparam logic [7:0] IDX_UNC_FULL_HI = 8'h0F;
  localparam logic [7:0] IDX_COMP_REM_LO = 8'h10;
  localparam logic [7:0] IDX_COMP_REM_HI = 8'h11;
  localparam logic [7:0] IDX_COMP_FULL_LO = 8'h12;
  localparam logic [7:0] IDX_COMP_FULL_HI = 8'h13;
  localparam logic [7:0] IDX_CURR_LO = 8'h14;
  localparam logic [7:0] IDX_CURR_HI = 8'h15;
  localparam logic [7:0] IDX_TEMP_LO = 8'h16;
  localparam logic [7:0] IDX_TEMP_HI = 8'h17;
  localparam logic [7:0] IDX_RES_LO = 8'h18;
  localparam logic [7:0] IDX_RES_HI = 8'h19;
  localparam logic [7:0] IDX_LEVEL_LO = 8'h1A;
  localparam logic [7:0] IDX_LEVEL_HI = 8'h1B;
  localparam logic [7:0] IDX_HEALTH_LO = 8'h1C;
  localparam logic [7:0] IDX_HEALTH_HI = 8'h1D;
  // Configuration register of our own: smoothing, scaling, threshold enables.
  localparam logic [7:0] IDX_CONFIG = 8'h40;

  localparam int ADDR_W = 10;

  // ---------------------------------------------------------------------------
  // Configuration bits
  // ---------------------------------------------------------------------------
  localparam int CFG_SMOOTH = 0;
  localparam int CFG_FAST_RES = 1;
  localparam int CFG_THR_EN = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;

  // ---------------------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------------------
  localparam int SB_CHGCTL = 13;
  localparam int SB_CAL = 12;
  localparam int SB_CHG_INH = 10;
  localparam int SB_FULL = 9;
  localparam int SB_CHG_EN = 8;
  localparam int SB_ILIM = 7;
  localparam int SB_MAX_SUPPORTED_CURRENT_STEP = 6;
  localparam int SB_OCV_GOOD = 5;
  localparam int SB_MLC = 4;
  localparam int SB_BAT = 3;
  localparam int SB_THR1 = 2;
  localparam int SB_DSG = 0;

  // ---------------------------------------------------------------------------
  // Health encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [7:0] {
    HS_INVALID = 8'h00,
    HS_INSTANT = 8'h01,
    HS_INITIAL = 8'h02,
    HS_READY = 8'h03
  } gsc_health_e;
  localparam logic [7:0] HEALTH_MAX = 8'h64;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic charger_control_active;
    logic calibration_active;
    logic charging_inhibited_by_command;
    logic full_charge_reached;
    logic charger_enable_n;
    logic input_current_limited;
    logic open_circuit_measure_good;
    logic multilevel_charge_on;
    logic battery_present;
    logic charge_threshold_reached;
    logic discharge_seen;
    logic normal_mode;
  } gsc_flags_s;

  typedef struct packed {
    logic [15:0] uncomp_remaining_charge;
    logic [15:0] uncomp_full_charge;
    logic [15:0] remaining_unfiltered;
    logic [15:0] remaining_filtered;
    logic [15:0] full_unfiltered;
    logic [15:0] full_filtered;
    logic [15:0] mean_sense_current;
    logic [15:0] die_temperature;
    logic [15:0] resistance_scale_factor;
    logic [15:0] multilevel_charge_step;
    logic [15:0] max_supported_current;
    logic [15:0] max_current_step;
    logic [7:0] health_percent;
  } gsc_meas_s;

  typedef struct packed {
    logic meas_update;
    logic current_update;
    logic capacity_update;
    logic grid_point_update;
    logic cell_inserted;
    logic charge_relax_done;
    logic instant_health;
    logic max_supported_current_clear;
  } gsc_evt_s;

endpackage

// file: gsc_regs.sv
/*
  Read-side register bank of the gauge status and capacity words.
  Assumes one AHB-Lite master on hclk and gauging logic on the same clock that
  delivers measured values, flags and one-cycle update events.
*/
module gsc_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire gsc_pkg::gsc_flags_s flags_in,
  input wire gsc_pkg::gsc_meas_s meas_in,
  input wire gsc_pkg::gsc_evt_s evt_in,
  output logic smoothing_select,
  output logic fast_resistance_scaling_enable,
  output logic threshold_flag_enable
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Magnitude of a difference, so the step detector works whatever the sign.
  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [2:0] cfg_r, cfg_nxt;
  logic [15:0] status_r, status_nxt;
  logic step_flag_r, step_flag_nxt;
  logic [15:0] last_max_supported_current_r, last_max_supported_current_nxt;
  logic [15:0] unc_rem_r, unc_rem_nxt;
  logic [15:0] unc_full_r, unc_full_nxt;
  logic [15:0] comp_rem_r, comp_rem_nxt;
  logic [15:0] comp_full_r, comp_full_nxt;
  // Filtered full capacity, held beside the unfiltered one in comp_full_r.
  logic [15:0] full_filt_r, full_filt_nxt;
  logic [15:0] curr_r, curr_nxt;
  logic [15:0] temp_r, temp_nxt;
  logic [15:0] res_r, res_nxt;
  logic [15:0] level_r, level_nxt;
  logic [7:0] health_pct_r, health_pct_nxt;
  gsc_pkg::gsc_health_e health_st_r, health_st_nxt;
  logic inserted_r, inserted_nxt;
  logic dp_act_r, dp_act_nxt;
  logic dp_wr_r, dp_wr_nxt;
  logic [7:0] dp_idx_r, dp_idx_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ready_r, ready_nxt;
  logic resp_r, resp_nxt;

  logic addr_ph;
  logic [7:0] rd_byte;
  logic [15:0] rd_word;
  logic rd_hi;
  logic rd_hit;

  assign addr_ph = hsel & hready & htrans[1];

  // ---------------------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------------------
  always_comb
  begin
    rd_word = 16'h0000;
    rd_hit = 1'b1;
    rd_hi = dp_idx_nxt[0];
    case ({dp_idx_nxt[7:1], 1'b0})
      gsc_pkg::IDX_STATUS_LO: rd_word = status_r;
      gsc_pkg::IDX_UNC_REM_LO: rd_word = unc_rem_r;
      gsc_pkg::IDX_UNC_FULL_LO: rd_word = unc_full_r;
      gsc_pkg::IDX_COMP_REM_LO: rd_word = comp_rem_r;
      gsc_pkg::IDX_COMP_FULL_LO:
      begin
        // Both figures are held, so a change of the select shows on the next read.
        rd_word = cfg_r[gsc_pkg::CFG_SMOOTH] ? full_filt_r : comp_full_r;
      end
      gsc_pkg::IDX_CURR_LO: rd_word = curr_r;
      gsc_pkg::IDX_TEMP_LO: rd_word = temp_r;
      gsc_pkg::IDX_RES_LO: rd_word = res_r;
      gsc_pkg::IDX_LEVEL_LO: rd_word = level_r;
      gsc_pkg::IDX_HEALTH_LO: rd_word = {health_st_r, health_pct_r};
      gsc_pkg::IDX_CONFIG: rd_word = {13'h0000, cfg_r};
      default:
      begin
        rd_word = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
    rd_byte = pick_byte(rd_word, rd_hi);
    if (dp_idx_nxt == gsc_pkg::IDX_CONFIG)
    begin
      rd_byte = {5'h00, cfg_r};
    end
    else if (dp_idx_nxt == (gsc_pkg::IDX_CONFIG + 8'h01))
    begin
      rd_byte = 8'h00;
    end
    if (!rd_hit)
    begin
      rd_byte = 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  // Zero wait states: read data is staged at the address phase so that it
  // stands in the following data phase.
  always_comb
  begin
    dp_act_nxt = addr_ph;
    dp_wr_nxt = addr_ph & hwrite;
    dp_idx_nxt = (haddr[31:gsc_pkg::ADDR_W] == '0) ? haddr[9:2] : 8'hFF;
    rdata_nxt = rdata_r;
    if (addr_ph && !hwrite)
    begin
      rdata_nxt = {24'h000000, rd_byte};
    end
    // Constant after reset, but kept in flip-flops like every bus output.
    ready_nxt = 1'b1;
    resp_nxt = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Configuration
  // ---------------------------------------------------------------------------
  // A read issued in the data phase of a config write still returns the old
  // value; software that needs the new one reads it one transfer later.
  always_comb
  begin
    cfg_nxt = cfg_r;
    // Only the configuration word accepts writes; others are read-only.
    if (dp_act_r && dp_wr_r && dp_idx_r == gsc_pkg::IDX_CONFIG)
    begin
      cfg_nxt = hwdata[2:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Status word and measurements
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic thr_en;
    thr_en = cfg_r[gsc_pkg::CFG_THR_EN];
    last_max_supported_current_nxt = last_max_supported_current_r;
    step_flag_nxt = step_flag_r;
    if (evt_in.max_supported_current_clear)
    begin
      step_flag_nxt = 1'b0;
    end
    // A step seen in the cycle of a clear wins, so no event is lost.
    if (evt_in.meas_update)
    begin
      last_max_supported_current_nxt = meas_in.max_supported_current;
      if (abs_diff(meas_in.max_supported_current, last_max_supported_current_r) > meas_in.max_current_step)
      begin
        step_flag_nxt = 1'b1;
      end
    end
    status_nxt = 16'h0000;
    status_nxt[gsc_pkg::SB_CHGCTL] = flags_in.charger_control_active;
    status_nxt[gsc_pkg::SB_CAL] = flags_in.calibration_active & ~flags_in.normal_mode;
    status_nxt[gsc_pkg::SB_CHG_INH] = flags_in.charging_inhibited_by_command;
    status_nxt[gsc_pkg::SB_FULL] = flags_in.full_charge_reached;
    status_nxt[gsc_pkg::SB_CHG_EN] = ~flags_in.charger_enable_n;
    status_nxt[gsc_pkg::SB_ILIM] = flags_in.input_current_limited;
    status_nxt[gsc_pkg::SB_MAX_SUPPORTED_CURRENT_STEP] = step_flag_nxt;
    status_nxt[gsc_pkg::SB_OCV_GOOD] = flags_in.open_circuit_measure_good;
    status_nxt[gsc_pkg::SB_MLC] = flags_in.multilevel_charge_on;
    status_nxt[gsc_pkg::SB_BAT] = flags_in.battery_present;
    status_nxt[gsc_pkg::SB_THR1] = thr_en & flags_in.charge_threshold_reached;
    status_nxt[gsc_pkg::SB_DSG] = flags_in.discharge_seen;

    unc_rem_nxt = evt_in.meas_update ? meas_in.uncomp_remaining_charge : unc_rem_r;
    unc_full_nxt = evt_in.capacity_update ? meas_in.uncomp_full_charge : unc_full_r;
    comp_rem_nxt = cfg_r[gsc_pkg::CFG_SMOOTH] ? meas_in.remaining_filtered
                                              : meas_in.remaining_unfiltered;
    comp_full_nxt = comp_full_r;
    full_filt_nxt = full_filt_r;
    if (evt_in.capacity_update)
    begin
      comp_full_nxt = meas_in.full_unfiltered;
      full_filt_nxt = meas_in.full_filtered;
    end
    curr_nxt = evt_in.current_update ? meas_in.mean_sense_current : curr_r;
    temp_nxt = meas_in.die_temperature;
    res_nxt = cfg_r[gsc_pkg::CFG_FAST_RES] ? meas_in.resistance_scale_factor
                                           : 16'h0000;
    level_nxt = meas_in.multilevel_charge_step;
    // Out-of-range figures are clamped rather than passed through.
    health_pct_nxt = (meas_in.health_percent > gsc_pkg::HEALTH_MAX) ? gsc_pkg::HEALTH_MAX
                                                                   : meas_in.health_percent;
  end

  // ---------------------------------------------------------------------------
  // Health status sequence
  // ---------------------------------------------------------------------------
  always_comb
  begin
    health_st_nxt = health_st_r;
    inserted_nxt = inserted_r;
    case (health_st_r)
      gsc_pkg::HS_INVALID:
      begin
        if (evt_in.instant_health)
        begin
          health_st_nxt = gsc_pkg::HS_INSTANT;
        end
      end
      gsc_pkg::HS_INSTANT:
      begin
        if (evt_in.grid_point_update && inserted_r)
        begin
          health_st_nxt = gsc_pkg::HS_INITIAL;
          inserted_nxt = 1'b0;
        end
      end
      gsc_pkg::HS_INITIAL:
      begin
        if (evt_in.charge_relax_done)
        begin
          health_st_nxt = gsc_pkg::HS_READY;
        end
      end
      gsc_pkg::HS_READY:
      begin
        health_st_nxt = gsc_pkg::HS_READY;
      end
      default:
      begin
        health_st_nxt = gsc_pkg::HS_INVALID;
      end
    endcase
    // Insertion wins over any other event in the same cycle, since the old
    // estimate no longer applies to the new cell.
    if (evt_in.cell_inserted)
    begin
      health_st_nxt = gsc_pkg::HS_INVALID;
      inserted_nxt = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_r <= gsc_pkg::CFG_RESET;
      status_r <= 16'h0000;
      step_flag_r <= 1'b0;
      last_max_supported_current_r <= 16'h0000;
      unc_rem_r <= 16'h0000;
      unc_full_r <= 16'h0000;
      comp_rem_r <= 16'h0000;
      comp_full_r <= 16'h0000;
      full_filt_r <= 16'h0000;
      curr_r <= 16'h0000;
      temp_r <= 16'h0000;
      res_r <= 16'h0000;
      level_r <= 16'h0000;
      health_pct_r <= 8'h00;
      health_st_r <= gsc_pkg::HS_INVALID;
      inserted_r <= 1'b0;
      dp_act_r <= 1'b0;
      dp_wr_r <= 1'b0;
      dp_idx_r <= 8'h00;
      rdata_r <= 32'h00000000;
      ready_r <= 1'b1;
      resp_r <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      status_r <= status_nxt;
      step_flag_r <= step_flag_nxt;
      last_max_supported_current_r <= last_max_supported_current_nxt;
      unc_rem_r <= unc_rem_nxt;
      unc_full_r <= unc_full_nxt;
      comp_rem_r <= comp_rem_nxt;
      comp_full_r <= comp_full_nxt;
      full_filt_r <= full_filt_nxt;
      curr_r <= curr_nxt;
      temp_r <= temp_nxt;
      res_r <= res_nxt;
      level_r <= level_nxt;
      health_pct_r <= health_pct_nxt;
      health_st_r <= health_st_nxt;
      inserted_r <= inserted_nxt;
      dp_act_r <= dp_act_nxt;
      dp_wr_r <= dp_wr_nxt;
      dp_idx_r <= dp_idx_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      resp_r <= resp_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  logic smooth_o_r, fast_o_r, thr_o_r;
  logic smooth_o_nxt, fast_o_nxt, thr_o_nxt;

  // The pins follow the written value at once rather than one cycle after the register.
  always_comb
  begin
    smooth_o_nxt = cfg_nxt[gsc_pkg::CFG_SMOOTH];
    fast_o_nxt = cfg_nxt[gsc_pkg::CFG_FAST_RES];
    thr_o_nxt = cfg_nxt[gsc_pkg::CFG_THR_EN];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      smooth_o_r <= 1'b0;
      fast_o_r <= 1'b0;
      thr_o_r <= 1'b0;
    end
    else
    begin
      smooth_o_r <= smooth_o_nxt;
      fast_o_r <= fast_o_nxt;
      thr_o_r <= thr_o_nxt;
    end
  end

  assign hrdata = rdata_r;
  assign hreadyout = ready_r;
  assign hresp = resp_r;
  assign smoothing_select = smooth_o_r;
  assign fast_resistance_scaling_enable = fast_o_r;
  assign threshold_flag_enable = thr_o_r;

endmodule

// file: gsc_regs_props.sv
/*
  Checker for the gauge status and capacity register bank, on its ports only.
  Assumes a bind from the bench top and hready fed back from hreadyout.
*/
module gsc_regs_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire gsc_pkg::gsc_flags_s flags_in,
  input wire gsc_pkg::gsc_meas_s meas_in,
  input wire gsc_pkg::gsc_evt_s evt_in,
  input wire logic smoothing_select,
  input wire logic fast_resistance_scaling_enable,
  input wire logic threshold_flag_enable
);
  // ---------------------------------------------------------------------------
  // Port relations
  // ---------------------------------------------------------------------------
  logic go;
  logic rd_go;
  logic cfg_wr;
  logic [7:0] idx;
  logic [7:0] hi_now;
  logic [7:0] lo_now;
  assign go = hsel && hready && htrans[1];
  assign rd_go = go && !hwrite && haddr[31:10] == 22'h0;
  assign cfg_wr = go && hwrite && haddr == 32'h100;
  assign idx = haddr[9:2];
  assign hi_now = {2'h0, flags_in.charger_control_active,
    flags_in.calibration_active & ~flags_in.normal_mode, 1'b0,
    flags_in.charging_inhibited_by_command, flags_in.full_charge_reached,
    ~flags_in.charger_enable_n};
  // Step and threshold bits hang on internal state, so they are masked and left to the bench.
  assign lo_now = {flags_in.input_current_limited, 1'b0, flags_in.open_circuit_measure_good,
    flags_in.multilevel_charge_on, flags_in.battery_present, 2'h0, flags_in.discharge_seen};

  default clocking dck @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  upper_zero_a:
    assert property (hrdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  cfg_hold_a:
    assert property (!$stable({smoothing_select, fast_resistance_scaling_enable,
      threshold_flag_enable}) |-> $past(cfg_wr, 2) || $past(cfg_wr, 3))
    else $error("config outputs moved without a config write");
  status_hi_a:
    assert property (rd_go && idx == 8'h0B |=> hrdata[7:0] == $past(hi_now, 2))
    else $error("status high byte mismatch");
  status_lo_a:
    assert property (rd_go && idx == 8'h0A |=> (hrdata[7:0] & 8'hBB) == $past(lo_now, 2))
    else $error("status low byte mismatch");
  temp_word_a:
    assert property (rd_go && idx == 8'h16 |=>
      hrdata[7:0] == $past(meas_in.die_temperature[7:0], 2))
    else $error("temperature low byte mismatch");
  health_pct_a:
    assert property (rd_go && idx == 8'h1C |=> hrdata[7:0] <= 8'h64)
    else $error("health percent above range");
  health_code_a:
    assert property (rd_go && idx == 8'h1D |=> hrdata[7:0] <= 8'h03)
    else $error("health status code reserved");
  unmapped_a:
    assert property (go && !hwrite && haddr[31:10] != 22'h0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

// file: gsc_host.sv
/*
  Bus host model issuing single-word AHB-Lite transfers.
  Assumes one slave whose hreadyout comes back as hready.
*/
module gsc_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic hung
);
  // ---------------------------------------------------------------------------
  // Transfers
  // ---------------------------------------------------------------------------
  assign hsize = 3'h2;
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hung = 1'b0;
  end
  // Waits are bounded so a silent slave raises a hang instead of stalling the run.
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    htrans <= 2'h0;
    hwdata <= wd;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    rd = hrdata;
    hsel <= 1'b0;
    if (n >= 64)
      hung <= 1'b1;
  endtask
endmodule

// file: tb_gauge_status_capacity_words.sv
/*
  Self-checking bench for the gauge status and capacity register bank.
  Assumes the host model for bus traffic; gauging inputs are driven here.
*/
module tb_gauge_status_capacity_words;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic hung;
  logic smooth;
  logic fast;
  logic thr_en;
  gsc_pkg::gsc_flags_s flags;
  gsc_pkg::gsc_meas_s meas;
  gsc_pkg::gsc_evt_s evt;
  int num_errors = 0;
  int n_compared = 0;

  gsc_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flags_in(flags), .meas_in(meas),
    .evt_in(evt), .smoothing_select(smooth), .fast_resistance_scaling_enable(fast),
    .threshold_flag_enable(thr_en));
  gsc_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hung(hung));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic wrap_up;
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    i_host.xfer(a, 1'b0, 32'h0, d);
    chk(what, exp, d);
    chk("response okay", 32'h0, {31'h0, hresp});
  endtask
  task automatic rd_word(input logic [7:0] i, input logic [15:0] w, input string what);
    rd({22'h0, i, 2'h0}, {24'h0, w[7:0]}, what);
    rd({22'h0, i + 8'h01, 2'h0}, {24'h0, w[15:8]}, what);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    i_host.xfer(a, 1'b1, d, unused);
    repeat (2) @(posedge hclk);
  endtask
  task automatic pulse(input gsc_pkg::gsc_evt_s e);
    @(posedge hclk);
    evt <= e;
    @(posedge hclk);
    evt <= '0;
    repeat (3) @(posedge hclk);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_words;
    logic [15:0] w [8];
    meas <= {16'h1234, 16'h2345, 16'h3456, 16'h4567, 16'h5678, 16'h6789, 16'hFF38,
      16'h0BB8, 16'h789A, 16'h0003, 16'h0100, 16'h0010, 8'h70};
    rd(32'h100, 32'h0, "config reset");
    rd_word(8'h0C, 16'h0000, "remaining before update");
    pulse(8'hE0);
    w = '{16'h1234, 16'h2345, 16'h3456, 16'h5678, 16'hFF38, 16'h0BB8, 16'h0000, 16'h0003};
    for (int k = 0; k < 8; k++)
      rd_word(8'h0C + 8'(2 * k), w[k], "data word");
    wr(32'h100, 32'h3);
    rd(32'h100, 32'h3, "config readback");
    chk("config outputs", 32'h3, {29'h0, thr_en, fast, smooth});
    rd(32'h104, 32'h0, "config spare");
    rd(32'h400, 32'h0, "unmapped read");
    rd_word(8'h10, 16'h4567, "filtered remaining");
    rd_word(8'h12, 16'h6789, "filtered full");
    rd_word(8'h18, 16'h789A, "resistance scale");
    wr(32'h100, 32'h0);
  endtask
  task automatic t_step;
    flags <= 12'h001;
    pulse(8'h01);
    rd(32'h28, 32'h0, "step cleared");
    meas.max_supported_current <= 16'h0110;
    pulse(8'h80);
    rd(32'h28, 32'h0, "step at limit");
    meas.max_supported_current <= 16'h0121;
    pulse(8'h80);
    rd(32'h28, 32'h40, "step beyond limit");
    pulse(8'h01);
    meas.max_supported_current <= 16'h0100;
    pulse(8'h81);
    rd(32'h28, 32'h40, "step set over clear");
    pulse(8'h01);
  endtask
  task automatic t_status;
    flags <= 12'hF7F;
    rd_word(8'h0A, 16'h27B9, "status all set");
    flags <= 12'h480;
    rd_word(8'h0A, 16'h1000, "status calibrating");
    wr(32'h100, 32'h4);
    flags <= 12'h005;
    rd_word(8'h0A, 16'h0104, "status threshold");
    wr(32'h28, 32'hFFFF_FFFF);
    rd(32'h28, 32'h04, "status after write");
  endtask
  task automatic t_health;
    logic [7:0] e [6];
    logic [7:0] c [6];
    e = '{8'h10, 8'h08, 8'h02, 8'h10, 8'h04, 8'h08};
    c = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h00};
    rd(32'h70, 32'h64, "health clamp");
    meas.health_percent <= 8'h50;
    rd(32'h70, 32'h50, "health percent");
    rd(32'h74, 32'h0, "health status reset");
    for (int k = 0; k < 6; k++)
    begin
      pulse(e[k]);
      rd(32'h74, {24'h0, c[k]}, "health status");
    end
  endtask

  task automatic t_reset;
    wr(32'h100, 32'h7);
    rd(32'h100, 32'h7, "config before reset");
    chk("config outputs set", 32'h7, {29'h0, thr_en, fast, smooth});
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("read data in reset", 32'h0, hrdata);
    chk("config outputs in reset", 32'h0, {29'h0, thr_en, fast, smooth});
    hresetn <= 1'b1;
    rd(32'h100, 32'h0, "config after reset");
  endtask

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk)
    if (hung === 1'b1)
    begin
      num_errors++;
      wrap_up();
    end
  initial
  begin
    hresetn = 1'b0;
    flags = '0;
    meas = '0;
    evt = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_words();
    t_step();
    t_status();
    t_health();
    t_reset();
    wrap_up();
  end
endmodule

bind gsc_regs gsc_regs_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .flags_in(flags_in), .meas_in(meas_in), .evt_in(evt_in), .smoothing_select(smoothing_select),
  .fast_resistance_scaling_enable(fast_resistance_scaling_enable),
  .threshold_flag_enable(threshold_flag_enable));
